// >>> retry_monitor_pkg.sv
// Purpose: Shared constants and types for the retry time-out monitor.
// Assumes: One clock; the bus clock also serves as the retry count clock.
// Notes: Register map is byte addressed, one aligned 32-bit word each.
package retry_monitor_pkg;

    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] RETRY_REG_ADDR = 12'h090;
    localparam logic [ADDR_W-1:0] RETRY_REG_F1_ADDR = 12'h0a0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h094;

    // Field positions in the retry register
    localparam int HOST_EN_BIT = 7;
    localparam int CARD_EN_BIT = 6;
    localparam int CARD_B_EXP_BIT = 5;
    localparam int CARD_A_EXP_BIT = 3;
    localparam int HOST_EXP_BIT = 1;

    // Reset values
    localparam logic [7:0] RETRY_RESET = 8'hc0;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic HOST_EN_RESET = RETRY_RESET[HOST_EN_BIT];
    localparam logic CARD_EN_RESET = RETRY_RESET[CARD_EN_BIT];

    // Retry limit: a power of two of count clock cycles
    localparam int RETRY_LIMIT_EXP = 15;
    localparam int RETRY_LIMIT_PCI_CYCLES = 2 ** RETRY_LIMIT_EXP;
    // Count clock runs at the bus clock rate, so the ratio is one
    localparam int CLK_PER_PCI_CYCLE = 1;
    localparam int RETRY_LIMIT_CYCLES = RETRY_LIMIT_PCI_CYCLES * CLK_PER_PCI_CYCLE;
    localparam int CNT_W = 17;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Events seen at one retried target
    typedef struct packed {
        logic retried;   // Device just answered a master with a retry
        logic returned;  // That master came back
    } retry_evt_s;

    // Wait tracker states, one-hot
    typedef enum logic [1:0] {
        WAIT_IDLE = 2'b01,
        WAIT_BUSY = 2'b10
    } wait_state_e;

endpackage

// >>> retry_wait_counter.sv
// Purpose: Times one retried master and pulses when it stays away too long.
// Assumes: Event pulses are one cycle wide and synchronous to clk.
// Notes: A fresh retry while already waiting keeps the running count.
module retry_wait_counter #(
    parameter int LIMIT = retry_monitor_pkg::RETRY_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire retry_monitor_pkg::retry_evt_s evt,
    output logic expired
);

    retry_monitor_pkg::wait_state_e state; // Waiting or not
    logic [retry_monitor_pkg::CNT_W-1:0] count; // Cycles waited so far
    logic atLimit; // Last cycle of the allowed wait

    assign atLimit = (count == retry_monitor_pkg::CNT_W'(LIMIT - 1));

    // Wait tracking and cycle count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= retry_monitor_pkg::WAIT_IDLE;
            count <= '0;
        end else begin
            case (state)
                retry_monitor_pkg::WAIT_IDLE: begin
                    count <= '0;
                    // Only an enabled counter starts timing
                    if (enable && evt.retried) begin
                        state <= retry_monitor_pkg::WAIT_BUSY; // RULE1
                    end
                end
                retry_monitor_pkg::WAIT_BUSY: begin
                    if (!enable) begin
                        // Disabled counter drops the wait
                        state <= retry_monitor_pkg::WAIT_IDLE; // RULE11
                        count <= '0;
                    end else if (evt.returned) begin
                        // Master back; a new retry restarts from zero
                        count <= '0; // RULE11
                        if (!evt.retried) begin
                            state <= retry_monitor_pkg::WAIT_IDLE;
                        end
                    end else if (atLimit) begin
                        state <= retry_monitor_pkg::WAIT_IDLE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1; // RULE1
                    end
                end
                default: begin
                    state <= retry_monitor_pkg::WAIT_IDLE;
                    count <= '0;
                end
            endcase
        end
    end

    // One-cycle expiry pulse when the full wait has passed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            expired <= 1'b0;
        end else begin
            expired <= (state == retry_monitor_pkg::WAIT_BUSY) && enable
                && !evt.returned && atLimit; // RULE1
        end
    end

endmodule

// >>> retry_timeout_monitor.sv
// Purpose: Retry time-out monitor with its control and status register.
// Assumes: AXI4-Lite master keeps one write and one read in flight at most.
// Notes: Both function views of the retry register share one copy.
//
// Behaviour
// (RULE1) Count 2^15 cycles after retry, then flag expiry
// (RULE2) Bit 7 enables host counter, resets one
// (RULE3) Bit 6 enables card counter, resets one
// (RULE4) Bit 5 flags card B expiry
// (RULE5) Bit 3 flags card A expiry
// (RULE6) Bit 1 flags host expiry
// (RULE7) Flags clear on write one, zero keeps
// (RULE8) Bits 4, 2, 0 always read zero
// (RULE9) Software uses function zero view only
// (RULE10) Card enable and A flag single shared copy
// (RULE11) Counter restarts on return or disable
module retry_timeout_monitor #(
    parameter int RETRY_LIMIT = retry_monitor_pkg::RETRY_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    // Retry events per target
    input wire retry_monitor_pkg::retry_evt_s hostEvt,
    input wire retry_monitor_pkg::retry_evt_s cardAEvt,
    input wire retry_monitor_pkg::retry_evt_s cardBEvt,
    // AXI4-Lite write address
    input wire logic [retry_monitor_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [retry_monitor_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [retry_monitor_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [retry_monitor_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Level interrupt
    output logic irq
);

    // Control bits
    logic host_retry_counter_en; // Host counter enable
    logic card_retry_counter_en; // Card counter enable, shared by both views

    // Sticky expiry flags
    logic host_retry_expired;
    logic card_a_retry_expired; // Shared by both views
    logic card_b_retry_expired;

    // Interrupt mask, same layout as the retry register
    logic [7:0] irqMask;

    // Expiry pulses from the counters
    logic hostExpire;
    logic cardAExpire;
    logic cardBExpire;

    // Write channel holding state
    logic awHeld; // Write address taken, waiting for data
    logic wHeld; // Write data taken, waiting for address
    logic [retry_monitor_pkg::ADDR_W-1:0] awAddr;
    logic [7:0] wByte; // Only the low byte carries register bits
    logic wLane0; // Strobe for the low byte
    logic next_awHeld;
    logic next_wHeld;
    logic next_bvalid;
    logic next_rvalid;
    logic doWrite; // Both halves present and response free

    // Write decode
    logic wrRetry; // Either view of the retry register
    logic wrMask;
    logic wrMapped;
    logic [7:0] clearBits; // Flags cleared this cycle

    // Read decode
    logic [7:0] retryView; // Assembled retry register
    logic rdRetry;
    logic rdMask;

    // Host counter
    retry_wait_counter #(
        .LIMIT(RETRY_LIMIT)
    ) hostCounter (
        .clk(clk),
        .reset_n(reset_n),
        .enable(host_retry_counter_en), // RULE2
        .evt(hostEvt),
        .expired(hostExpire)
    );

    // Card A counter, gated by the shared card enable
    retry_wait_counter #(
        .LIMIT(RETRY_LIMIT)
    ) cardACounter (
        .clk(clk),
        .reset_n(reset_n),
        .enable(card_retry_counter_en), // RULE3
        .evt(cardAEvt),
        .expired(cardAExpire)
    );

    // Card B counter, gated by the shared card enable
    retry_wait_counter #(
        .LIMIT(RETRY_LIMIT)
    ) cardBCounter (
        .clk(clk),
        .reset_n(reset_n),
        .enable(card_retry_counter_en), // RULE3
        .evt(cardBEvt),
        .expired(cardBExpire)
    );

    // Write handshake bookkeeping
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_bvalid = s_axi_bvalid;
        // Take each half as it arrives, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
        end
        // Response retires on the master's ready
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
        end
    end

    // Read handshake bookkeeping
    always_comb begin
        next_rvalid = s_axi_rvalid;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
        end
    end

    // Write address capture and ready
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            awAddr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            awHeld <= next_awHeld;
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr <= s_axi_awaddr;
            end
            // Ready only while no address is parked and no response is pending
            s_axi_awready <= !next_awHeld && !next_bvalid;
        end
    end

    // Write data capture and ready
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wHeld <= 1'b0;
            wByte <= '0;
            wLane0 <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            wHeld <= next_wHeld;
            if (s_axi_wvalid && s_axi_wready) begin
                wByte <= s_axi_wdata[7:0];
                wLane0 <= s_axi_wstrb[0];
            end
            s_axi_wready <= !next_wHeld && !next_bvalid;
        end
    end

    // Write decode; both offsets reach the same bits
    assign wrRetry = (awAddr == retry_monitor_pkg::RETRY_REG_ADDR)
        || (awAddr == retry_monitor_pkg::RETRY_REG_F1_ADDR); // RULE10
    assign wrMask = (awAddr == retry_monitor_pkg::IRQ_MASK_ADDR);
    assign wrMapped = wrRetry || wrMask;

    // A one written to a flag position clears it; zero leaves it
    assign clearBits = (doWrite && wrRetry && wLane0) ? wByte : 8'h00; // RULE7

    // Write response
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= retry_monitor_pkg::RESP_OKAY;
        end else begin
            s_axi_bvalid <= next_bvalid;
            if (doWrite) begin
                // Unmapped addresses answer with an error
                s_axi_bresp <= wrMapped ? retry_monitor_pkg::RESP_OKAY
                    : retry_monitor_pkg::RESP_SLVERR;
            end
        end
    end

    // Counter enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_retry_counter_en <= retry_monitor_pkg::HOST_EN_RESET; // RULE2
            card_retry_counter_en <= retry_monitor_pkg::CARD_EN_RESET; // RULE3
        end else if (doWrite && wrRetry && wLane0) begin
            host_retry_counter_en <= wByte[retry_monitor_pkg::HOST_EN_BIT]; // RULE2
            // Single copy, written through either view
            card_retry_counter_en <= wByte[retry_monitor_pkg::CARD_EN_BIT]; // RULE3 RULE10
        end
    end

    // Sticky expiry flags; a new expiry beats a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_retry_expired <= 1'b0;
            card_a_retry_expired <= 1'b0;
            card_b_retry_expired <= 1'b0;
        end else begin
            host_retry_expired <= hostExpire
                || (host_retry_expired
                && !clearBits[retry_monitor_pkg::HOST_EXP_BIT]); // RULE6 RULE7
            card_a_retry_expired <= cardAExpire
                || (card_a_retry_expired
                && !clearBits[retry_monitor_pkg::CARD_A_EXP_BIT]); // RULE5 RULE7 RULE10
            card_b_retry_expired <= cardBExpire
                || (card_b_retry_expired
                && !clearBits[retry_monitor_pkg::CARD_B_EXP_BIT]); // RULE4 RULE7
        end
    end

    // Interrupt mask; only flag positions are kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask <= retry_monitor_pkg::IRQ_MASK_RESET;
        end else if (doWrite && wrMask && wLane0) begin
            irqMask <= '0;
            irqMask[retry_monitor_pkg::HOST_EXP_BIT] <=
                wByte[retry_monitor_pkg::HOST_EXP_BIT];
            irqMask[retry_monitor_pkg::CARD_A_EXP_BIT] <=
                wByte[retry_monitor_pkg::CARD_A_EXP_BIT];
            irqMask[retry_monitor_pkg::CARD_B_EXP_BIT] <=
                wByte[retry_monitor_pkg::CARD_B_EXP_BIT];
        end
    end

    // Retry register image; unlisted positions stay zero
    always_comb begin
        retryView = 8'h00; // RULE8
        retryView[retry_monitor_pkg::HOST_EN_BIT] = host_retry_counter_en;
        retryView[retry_monitor_pkg::CARD_EN_BIT] = card_retry_counter_en;
        retryView[retry_monitor_pkg::CARD_B_EXP_BIT] = card_b_retry_expired;
        retryView[retry_monitor_pkg::CARD_A_EXP_BIT] = card_a_retry_expired;
        retryView[retry_monitor_pkg::HOST_EXP_BIT] = host_retry_expired;
    end

    // Read decode; both views return the same image
    assign rdRetry = (s_axi_araddr == retry_monitor_pkg::RETRY_REG_ADDR)
        || (s_axi_araddr == retry_monitor_pkg::RETRY_REG_F1_ADDR); // RULE10
    assign rdMask = (s_axi_araddr == retry_monitor_pkg::IRQ_MASK_ADDR);

    // Read channel; data is captured when the address is taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= retry_monitor_pkg::RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            // One read at a time: no new address while data waits
            s_axi_arready <= !next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                if (rdRetry) begin
                    s_axi_rdata <= {24'h000000, retryView}; // RULE8
                    s_axi_rresp <= retry_monitor_pkg::RESP_OKAY;
                end else if (rdMask) begin
                    s_axi_rdata <= {24'h000000, irqMask};
                    s_axi_rresp <= retry_monitor_pkg::RESP_OKAY;
                end else begin
                    // Unmapped: zero data and an error
                    s_axi_rdata <= '0;
                    s_axi_rresp <= retry_monitor_pkg::RESP_SLVERR;
                end
            end
        end
    end

    // Interrupt level; registered so it lags the flags by one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(retryView & irqMask);
        end
    end

endmodule

// >>> retry_monitor_checker_assertions.sv
// Purpose: Port-level checks of the retry time-out monitor.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Sees only the top ports; bound in at the foot of this file.
module retry_monitor_checker #(
    parameter int RETRY_LIMIT = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire retry_monitor_pkg::retry_evt_s hostEvt,
    input wire retry_monitor_pkg::retry_evt_s cardAEvt,
    input wire retry_monitor_pkg::retry_evt_s cardBEvt,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    retry_monitor_pkg::retry_evt_s ev [3]; // Events by target
    logic [2:0] wt; // Target has a master away
    int cnt [3]; // Cycles that master has been away
    logic seen; // Some wait has run long enough to expire
    logic [11:0] arQ; // Address of the read in flight
    logic mapped; // That address hits a register
    assign ev[0] = hostEvt;
    assign ev[1] = cardAEvt;
    assign ev[2] = cardBEvt;
    assign mapped = arQ inside {retry_monitor_pkg::RETRY_REG_ADDR,
        retry_monitor_pkg::RETRY_REG_F1_ADDR, retry_monitor_pkg::IRQ_MASK_ADDR};
    // Shadow wait timers; loose on purpose, enables are not tracked
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wt <= 3'h0;
            seen <= 1'b0;
            cnt <= '{default: 0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ev[i].returned) begin
                    wt[i] <= ev[i].retried;
                    cnt[i] <= 0;
                end else if (ev[i].retried && !wt[i]) begin
                    wt[i] <= 1'b1;
                    cnt[i] <= 0;
                end else if (wt[i]) begin
                    cnt[i] <= cnt[i] + 1;
                end
                if (wt[i] && cnt[i] >= RETRY_LIMIT - 1) seen <= 1'b1;
            end
        end
    end
    // Remember the read address for the response check
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) arQ <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) arQ <= s_axi_araddr;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    reserved_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
        !s_axi_rdata[4] && !s_axi_rdata[2] && !s_axi_rdata[0]) else $error("reserved bit set");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_reopen_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write side not reopened");
    resp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ?
        retry_monitor_pkg::RESP_OKAY : retry_monitor_pkg::RESP_SLVERR) &&
        (mapped || s_axi_rdata == 32'h0)) else $error("wrong read response");
    irq_cause_a: assert property ($rose(irq) |-> seen)
        else $error("interrupt before any wait expired");
endmodule

bind retry_timeout_monitor retry_monitor_checker #(.RETRY_LIMIT(RETRY_LIMIT)) u_chk (
    .clk, .reset_n, .hostEvt, .cardAEvt, .cardBEvt, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);

// >>> retry_master_model.sv
// Purpose: Far-side bus masters that get retried and may come back.
// Assumes: One request at a time; events are one-cycle pulses.
// Notes: A delay of zero models a master that never returns.
module retry_master_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic [1:0] tgt,
    input wire logic [7:0] dly,
    output retry_monitor_pkg::retry_evt_s hostEvt,
    output retry_monitor_pkg::retry_evt_s cardAEvt,
    output retry_monitor_pkg::retry_evt_s cardBEvt
);
    timeunit 1ns;
    timeprecision 1ps;
    retry_monitor_pkg::retry_evt_s evt [3]; // One event pair per target
    logic [7:0] left; // Cycles until the master comes back
    logic [1:0] who; // Target the pending master waits on
    assign hostEvt = evt[0];
    assign cardAEvt = evt[1];
    assign cardBEvt = evt[2];
    // Retry pulse on request, return pulse when the delay runs out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evt <= '{default: '0};
            left <= 8'h00;
            who <= 2'h0;
        end else begin
            evt <= '{default: '0};
            if (go) begin
                evt[tgt].retried <= 1'b1;
                left <= dly;
                who <= tgt;
            end else if (left != 8'h00) begin
                left <= left - 8'h01;
                if (left == 8'h01) evt[who].returned <= 1'b1;
            end
        end
    end
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the retry time-out monitor.
// Assumes: Short retry limit; software writes through the function zero view only.
// Notes: Read and write answers are checked from expectation queues.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int L = 16; // Short limit keeps the run brief
    localparam logic [11:0] RA = retry_monitor_pkg::RETRY_REG_ADDR;
    localparam logic [11:0] MA = retry_monitor_pkg::IRQ_MASK_ADDR;
    localparam logic [1:0] OK = retry_monitor_pkg::RESP_OKAY;
    localparam logic [1:0] SE = retry_monitor_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, r;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, go;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, tgt;
    logic [7:0] dly, fl;
    retry_monitor_pkg::retry_evt_s hEv, aEv, bEv;
    logic [33:0] expR [$]; // Pending read answers
    logic [1:0] expB [$]; // Pending write answers
    int badCount = 0;
    int checked = 0;
    int cyc = 0;
    integer seed;
    always #2.5 clk = ~clk;
    retry_master_model u_retry_master_model (.clk(clk), .reset_n(reset_n), .go(go),
        .tgt(tgt), .dly(dly), .hostEvt(hEv), .cardAEvt(aEv), .cardBEvt(bEv));
    retry_timeout_monitor #(.RETRY_LIMIT(L)) u_retry_timeout_monitor (.clk(clk),
        .reset_n(reset_n), .hostEvt(hEv), .cardAEvt(aEv), .cardBEvt(bEv),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    task automatic stopTest();
        if (badCount == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write one word; address and data are released as each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        expB.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clk); // Let an edge pass so the next call does not re-drive bready at once
    endtask
    // Read one word; the answer is judged by the monitor process
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        expR.push_back({e, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge clk); // Let an edge pass so the next call does not re-drive rready at once
    endtask
    // Retry one master; a zero delay means it stays away
    task automatic retry(input logic [1:0] t, input logic [7:0] d, input int w);
        tgt <= t;
        dly <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (w) @(posedge clk);
    endtask
    task automatic irqIs(input logic e);
        repeat (2) @(posedge clk);
        #1 check({33'h0, irq}, {33'h0, e});
    endtask
    // Take answers as they appear and bound the run
    always @(posedge clk) begin
        if (rvalid && rready) check({rresp, rdata}, expR.pop_front());
        if (bvalid && bready) check({32'h0, bresp}, {32'h0, expB.pop_front()});
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            badCount++;
            stopTest();
        end
    end
    initial begin
        seed = 19;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, go} = '0;
        {tgt, dly, fl} = '0;
        wstrb = 4'hf;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(RA, 8'hc0, OK);
        rd(MA, 8'h00, OK);
        rd(12'h098, 8'h00, SE);
        wr(12'h098, 32'hffffffff, SE);
        r = $random(seed);
        wr(MA, r, OK);
        rd(MA, r[7:0] & 8'h2a, OK);
        wr(RA, {r[31:8], 8'hd5}, OK);
        rd(RA, 8'hc0, OK);
        wr(MA, 32'h2a, OK);
        // Each target in turn lets its master stay away
        for (int i = 0; i < 3; i++) begin
            retry(2'(i), 8'h00, L + 4);
            fl = fl | (8'h02 << (2 * i));
            rd(RA, 8'hc0 | fl, OK);
            irqIs(1'b1);
        end
        rd(retry_monitor_pkg::RETRY_REG_F1_ADDR, 8'hea, OK);
        wr(RA, 32'hc0, OK);
        rd(RA, 8'hea, OK);
        wr(MA, 32'h00, OK);
        irqIs(1'b0);
        wr(MA, 32'h2a, OK);
        wr(RA, 32'hc8, OK);
        rd(RA, 8'he2, OK);
        wr(RA, 32'hc2 | (r & 32'h20), OK);
        rd(RA, 8'hc0 | (8'h20 & ~r[7:0]), OK);
        wr(RA, 32'hea, OK);
        irqIs(1'b0);
        retry(2'h0, 8'(L - 4), L + 4);
        rd(RA, 8'hc0, OK);
        wr(RA, 32'h40, OK);
        retry(2'h0, 8'h00, L + 4);
        rd(RA, 8'h40, OK);
        wr(RA, 32'h80, OK);
        retry(2'h1, 8'h00, L + 4);
        rd(RA, 8'h80, OK);
        wr(RA, 32'hc0, OK);
        retry(2'h2, 8'h00, 2);
        wr(RA, 32'h80, OK);
        wr(RA, 32'hc0, OK);
        repeat (L + 4) @(posedge clk);
        rd(RA, 8'hc0, OK);
        repeat (4) @(posedge clk);
        stopTest();
    end
endmodule
